// ### src/gpo_delay_chan.sv
`timescale 1ns/100ps
`include "gpo_seq_defs.svh"

// one output channel: delays each edge of its control signal
module gpo_delay_chan
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tick,
  input wire logic ctrl,
  input wire gpo_seq_pkg::delay_reg_t dly,
  input wire logic rise_scale,
  input wire logic fall_scale,
  output logic out_r
);

  typedef enum logic [1:0] {IDLE, WAIT_RISE, WAIT_FALL} chan_state_t;

  chan_state_t state_r;
  logic ctrl_q_r;
  logic [4:0] cnt_r;
  logic [4:0] target;

  // 1 ms steps are simply two 0.5 ms ticks
  always_comb
  begin
    if (ctrl)
      target = rise_scale ? {dly.rise, 1'b0} : {1'b0, dly.rise};
    else
      target = fall_scale ? {dly.fall, 1'b0} : {1'b0, dly.fall};
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ctrl_q_r <= 1'b0;
    else
      ctrl_q_r <= ctrl;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_r <= IDLE;
      cnt_r <= 5'h00;
      out_r <= 1'b0;
    end
    else if (ctrl != ctrl_q_r)
    begin
      // any new edge restarts timing and drops a pending one
      cnt_r <= 5'h00;
      if (target == 5'h00)
      begin
        out_r <= ctrl;
        state_r <= IDLE;
      end
      else
        state_r <= ctrl ? WAIT_RISE : WAIT_FALL; // [R16]
    end
    else
    begin
      unique case (state_r)
        IDLE: ;
        WAIT_RISE, WAIT_FALL:
        begin
          if (tick)
          begin
            if (cnt_r + 5'h01 >= target) // [R1] [R2] [R3]
            begin
              out_r <= (state_r == WAIT_RISE);
              state_r <= IDLE;
            end
            cnt_r <= cnt_r + 5'h01;
          end
        end
        default: state_r <= IDLE;
      endcase
    end
  end

endmodule

// ### src/gpo_seq_defs.svh
`ifndef GPO_SEQ_DEFS_SVH
`define GPO_SEQ_DEFS_SVH

// register indices; byte address is four times the index
`define IDX_OUT0_DELAY 8'h0c
`define IDX_OUT1_DELAY 8'h0d
`define IDX_OUT2_DELAY 8'h0e
`define IDX_CTRL_FIRST 8'h0f
`define IDX_CTRL_SECOND 8'h10
`define IDX_CONFIG 8'h11

// documented reset values of the OTP image
`define RST_DELAY 8'h00
`define RST_CTRL_FIRST 8'haa
`define RST_CTRL_SECOND 8'h0a
`define RST_CONFIG 8'h3c

// field positions
`define F_FALL_HI 7
`define F_FALL_LO 4
`define F_RISE_HI 3
`define F_RISE_LO 0
`define F_A_LEVEL 0
`define F_A_GATE_LO 1
`define F_A_DRAIN 3
`define F_B_LEVEL 4
`define F_B_GATE_LO 5
`define F_B_DRAIN 7
`define F_C_LEVEL 0
`define F_C_GATE_LO 1
`define F_C_DRAIN 3
`define F_B_SEL 4
`define F_C_SEL 5
`define F_RISE_SCALE 7
`define F_FALL_SCALE 6

// timing: one delay step is 500 us, clock runs at 20 MHz
`define STEP_US 500
`define CLK_MHZ 20
`define STEP_CYCLES (`STEP_US * `CLK_MHZ)

`endif

// ### src/gpo_seq_pkg.sv
package gpo_seq_pkg;

  typedef struct packed {
    logic [3:0] fall;
    logic [3:0] rise;
  } delay_reg_t;

  typedef enum logic [1:0] {
    GATE_NONE,
    GATE_EN1,
    GATE_EN2,
    GATE_EN3
  } gating_t;

  typedef struct packed {
    logic drain;
    gating_t gating;
    logic level;
  } out_cfg_t;

endpackage

// ### src/gpo_seq_top.sv
`timescale 1ns/100ps
`include "gpo_seq_defs.svh"

// What this block does
// R1: output a falls after its fall delay: code times 0.5 ms, 0 to 7.5 ms.
// R2: output a rises after its rise delay in the low nibble, same steps.
// R3: with rise scale set, every rise step doubles to 1 ms, up to 15 ms.
// R4: output b has its own fall and rise delays, same coding and scale.
// R5: output c has its own fall and rise delays, same coding and scale.
// R6: drain bit 3 makes output a open-drain, bit 7 does so for output b.
// R7: b gating at bits 6-5: level alone, or level AND enable one/two/three.
// R8: a gating at bits 2-1: level alone, or level AND enable one/two/three.
// R9: when pin set to output b, bit 4 gives its level.
// R10: bit 0 gives output a level, subject to its gating.
// R11: gating code 2 asserts output a only while enable two and level high.
// R12: all reset values load from the OTP image, not constants.
// R13: output c gating at bits 2-1 chooses the same four sources.
// R14: config bit 7 selects rise range 7.5 ms or 15 ms.
// R15: config bit 6 selects fall range 7.5 ms or 15 ms.
// R16: a control change during a pending delay restarts the timing.
// R17: delays count a 0.5 ms reference tick.
module gpo_seq_top
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] otp_out0_delay,
  input wire logic [7:0] otp_out1_delay,
  input wire logic [7:0] otp_out2_delay,
  input wire logic [7:0] otp_ctrl_first,
  input wire logic [7:0] otp_ctrl_second,
  input wire logic [7:0] otp_config,
  input wire logic enable_pin_one,
  input wire logic enable_pin_two,
  input wire logic enable_pin_three,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic general_out_a_o,
  output logic general_out_a_oe_n,
  output logic general_out_b_o,
  output logic general_out_b_oe_n,
  output logic power_good_sel,
  output logic general_out_c_o,
  output logic general_out_c_oe_n,
  output logic general_out_c_sel
);

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int STEP_CYC = `STEP_CYCLES;

  gpo_seq_pkg::delay_reg_t dly_r [3];
  logic [7:0] ctrl1_r;
  logic [7:0] ctrl2_r;
  logic [7:0] cfg_r;
  logic load_done_r;
  logic [2:0] en_s1_r;
  logic [2:0] en_s2_r;
  logic [13:0] div_r;
  logic tick_r;
  logic [2:0] ctrl_r;
  logic [2:0] seq_out;
  logic aw_held_r;
  logic w_held_r;
  logic [7:0] aw_idx_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic [7:0] ar_idx;
  gpo_seq_pkg::out_cfg_t cfg_a;
  gpo_seq_pkg::out_cfg_t cfg_b;
  gpo_seq_pkg::out_cfg_t cfg_c;
  logic wr_fire;
  logic aw_hit;

  assign cfg_a = gpo_seq_pkg::out_cfg_t'(ctrl1_r[`F_A_DRAIN:`F_A_LEVEL]);
  assign cfg_b = gpo_seq_pkg::out_cfg_t'(ctrl1_r[`F_B_DRAIN:`F_B_LEVEL]);
  assign cfg_c = gpo_seq_pkg::out_cfg_t'(ctrl2_r[`F_C_DRAIN:`F_C_LEVEL]);

  // enable pins come from outside the clock domain
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      en_s1_r <= 3'h0;
      en_s2_r <= 3'h0;
    end
    else
    begin
      en_s1_r <= {enable_pin_three, enable_pin_two, enable_pin_one};
      en_s2_r <= en_s1_r;
    end
  end

  // 0.5 ms reference tick shared by all channels
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      div_r <= 14'h0000;
      tick_r <= 1'b0;
    end
    else if (div_r == 14'(STEP_CYC - 1))
    begin
      div_r <= 14'h0000;
      tick_r <= 1'b1; // [R17]
    end
    else
    begin
      div_r <= div_r + 14'h0001;
      tick_r <= 1'b0;
    end
  end

  function automatic logic gated(gpo_seq_pkg::out_cfg_t c, logic [2:0] en);
    unique case (c.gating)
      gpo_seq_pkg::GATE_NONE: gated = c.level;
      gpo_seq_pkg::GATE_EN1: gated = c.level & en[0];
      gpo_seq_pkg::GATE_EN2: gated = c.level & en[1];
      gpo_seq_pkg::GATE_EN3: gated = c.level & en[2];
    endcase
  endfunction

  // control signal of each channel, registered to keep it glitch free
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !load_done_r)
      ctrl_r <= 3'h0;
    else
    begin
      ctrl_r[0] <= gated(cfg_a, en_s2_r); // [R8] [R10] [R11]
      ctrl_r[1] <= gated(cfg_b, en_s2_r); // [R7] [R9]
      ctrl_r[2] <= gated(cfg_c, en_s2_r); // [R13]
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_chan
      gpo_delay_chan u_chan
      (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(tick_r),
        .ctrl(ctrl_r[gi]),
        .dly(dly_r[gi]), // [R4] [R5]
        .rise_scale(cfg_r[`F_RISE_SCALE]), // [R14]
        .fall_scale(cfg_r[`F_FALL_SCALE]), // [R15]
        .out_r(seq_out[gi])
      );
    end
  endgenerate

  // open-drain: never drive high, release instead
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      general_out_a_o <= 1'b0;
      general_out_a_oe_n <= 1'b1;
      general_out_b_o <= 1'b0;
      general_out_b_oe_n <= 1'b1;
      general_out_c_o <= 1'b0;
      general_out_c_oe_n <= 1'b1;
      power_good_sel <= 1'b1;
      general_out_c_sel <= 1'b0;
    end
    else
    begin
      general_out_a_o <= seq_out[0];
      general_out_a_oe_n <= cfg_a.drain & seq_out[0]; // [R6]
      general_out_b_o <= seq_out[1];
      general_out_b_oe_n <= cfg_b.drain & seq_out[1]; // [R6]
      general_out_c_o <= seq_out[2];
      general_out_c_oe_n <= cfg_c.drain & seq_out[2];
      power_good_sel <= ~ctrl2_r[`F_B_SEL];
      general_out_c_sel <= ctrl2_r[`F_C_SEL];
    end
  end

  // write path: address and data may arrive in either order
  assign wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;
  assign aw_hit = aw_idx_r >= `IDX_OUT0_DELAY && aw_idx_r <= `IDX_CONFIG;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_r <= 1'b0;
      aw_idx_r <= 8'h00;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held_r <= 1'b1;
      aw_idx_r <= s_axi_awaddr[9:2];
    end
    else if (wr_fire)
      aw_held_r <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held_r <= 1'b0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held_r <= 1'b1;
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
    end
    else if (wr_fire)
      w_held_r <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !aw_held_r && !(s_axi_awvalid && s_axi_awready)
        && !s_axi_bvalid;
      s_axi_wready <= !w_held_r && !(s_axi_wvalid && s_axi_wready)
        && !s_axi_bvalid;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= aw_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // registers start from the OTP image one cycle after reset release
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      load_done_r <= 1'b0;
      for (int i = 0; i < 3; i++)
        dly_r[i] <= `RST_DELAY;
      ctrl1_r <= `RST_CTRL_FIRST;
      ctrl2_r <= `RST_CTRL_SECOND;
      cfg_r <= `RST_CONFIG;
    end
    else if (!load_done_r)
    begin
      load_done_r <= 1'b1;
      dly_r[0] <= otp_out0_delay; // [R12]
      dly_r[1] <= otp_out1_delay;
      dly_r[2] <= otp_out2_delay;
      ctrl1_r <= otp_ctrl_first;
      ctrl2_r <= otp_ctrl_second;
      cfg_r <= otp_config;
    end
    else if (wr_fire && wstrb_r[0])
    begin
      unique case (aw_idx_r)
        `IDX_OUT0_DELAY: dly_r[0] <= wdata_r[7:0];
        `IDX_OUT1_DELAY: dly_r[1] <= wdata_r[7:0];
        `IDX_OUT2_DELAY: dly_r[2] <= wdata_r[7:0];
        `IDX_CTRL_FIRST: ctrl1_r <= wdata_r[7:0];
        `IDX_CTRL_SECOND: ctrl2_r <= wdata_r[7:0];
        `IDX_CONFIG: cfg_r <= wdata_r[7:0];
        default: ;
      endcase
    end
  end

  // read path: one cycle from address taken to data
  assign ar_idx = s_axi_araddr[9:2];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s_axi_arready <= 1'b0;
    else
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      unique case (ar_idx)
        `IDX_OUT0_DELAY: s_axi_rdata <= {24'h0, dly_r[0]};
        `IDX_OUT1_DELAY: s_axi_rdata <= {24'h0, dly_r[1]};
        `IDX_OUT2_DELAY: s_axi_rdata <= {24'h0, dly_r[2]};
        `IDX_CTRL_FIRST: s_axi_rdata <= {24'h0, ctrl1_r};
        `IDX_CTRL_SECOND: s_axi_rdata <= {24'h0, ctrl2_r};
        `IDX_CONFIG: s_axi_rdata <= {24'h0, cfg_r};
        default:
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  property p_tick_period;
    @(posedge aclk) disable iff (!aresetn)
      tick_r |=> !tick_r [*8];
  endproperty
  a_tick_period: assert property (p_tick_period) // [R17]
    else $error("tick repeats too soon");

  property p_gate_two;
    @(posedge aclk) disable iff (!aresetn)
      load_done_r && cfg_a.gating == gpo_seq_pkg::GATE_EN2 && !en_s2_r[1]
      |=> !ctrl_r[0];
  endproperty
  a_gate_two: assert property (p_gate_two) // [R11]
    else $error("output a control high without enable two");

  property p_level_alone;
    @(posedge aclk) disable iff (!aresetn)
      load_done_r && cfg_b.gating == gpo_seq_pkg::GATE_NONE
      |=> ctrl_r[1] == $past(cfg_b.level);
  endproperty
  a_level_alone: assert property (p_level_alone) // [R7]
    else $error("output b control not following level");

  property p_drain_release;
    @(posedge aclk) disable iff (!aresetn)
      cfg_a.drain && seq_out[0] |=> general_out_a_oe_n;
  endproperty
  a_drain_release: assert property (p_drain_release) // [R6]
    else $error("open-drain output a driven high");

  property p_push_pull;
    @(posedge aclk) disable iff (!aresetn)
      !cfg_b.drain |=> !general_out_b_oe_n;
  endproperty
  a_push_pull: assert property (p_push_pull) // [R6]
    else $error("push-pull output b released");

  property p_zero_delay;
    @(posedge aclk) disable iff (!aresetn)
      $rose(ctrl_r[2]) && dly_r[2].rise == 4'h0 |=> seq_out[2];
  endproperty
  a_zero_delay: assert property (p_zero_delay) // [R5]
    else $error("zero rise delay not immediate on output c");

  // the tick runs free, so a delayed rise can come early but only on a tick
  property p_rise_hold;
    @(posedge aclk) disable iff (!aresetn)
      $rose(seq_out[0]) && $past(dly_r[0].rise) != 4'h0
      |-> $past(tick_r);
  endproperty
  a_rise_hold: assert property (p_rise_hold) // [R2]
    else $error("output a rose off a reference tick");

  property p_otp_load;
    @(posedge aclk) disable iff (!aresetn)
      !load_done_r |=> ctrl1_r == $past(otp_ctrl_first);
  endproperty
  a_otp_load: assert property (p_otp_load) // [R12]
    else $error("control not loaded from otp");

  property p_bresp;
    @(posedge aclk) disable iff (!aresetn)
      wr_fire |=> s_axi_bvalid;
  endproperty
  a_bresp: assert property (p_bresp)
    else $error("write not answered");

  c_rise: cover property (@(posedge aclk) $rose(seq_out[0]));
  c_fall: cover property (@(posedge aclk) $fell(seq_out[1]));
  c_write: cover property (@(posedge aclk) wr_fire && aw_hit);
  c_read: cover property (@(posedge aclk) s_axi_rvalid && s_axi_rready);

endmodule

// ### test/host_pins_model.sv
`timescale 1ns/100ps

// host side of the block: drives the enable pins and resolves the pads
module host_pins_model
(
  input wire logic aclk,
  input wire logic [2:0] en_req,
  input wire logic [2:0] pad_o,
  input wire logic [2:0] pad_oe_n,
  output logic enable_pin_one,
  output logic enable_pin_two,
  output logic enable_pin_three,
  output logic [2:0] pad_level
);
  // levels move only just after an edge, like any synchronous host
  always @(posedge aclk)
  begin
    enable_pin_one <= en_req[0];
    enable_pin_two <= en_req[1];
    enable_pin_three <= en_req[2];
  end

  // a released open-drain pad is pulled up on the board, never left floating
  assign pad_level = pad_oe_n | (~pad_oe_n & pad_o);
endmodule

// ### test/tb.sv
`timescale 1ns/100ps
`include "gpo_seq_defs.svh"

`define CHK(nm, got, exp) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) \
    begin \
      $display("unexpected %s exp %h got %h", nm, exp, got); \
      num_errors++; \
    end \
  end

module tb;
  localparam int t_step = `STEP_CYCLES;
  localparam logic [7:0] otp_d0 = 8'h00;
  localparam logic [7:0] otp_d1 = 8'h21;
  localparam logic [7:0] otp_d2 = 8'h12;
  localparam logic [7:0] otp_c1 = 8'h81;
  localparam logic [7:0] otp_c2 = 8'h30;
  localparam logic [7:0] otp_cfg = 8'h00;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] awaddr = 32'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] araddr = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [2:0] en_req = 3'h7;
  logic hi_seen = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, pg_sel, c_sel;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  wire [2:0] o, oe_n, pin;
  wire en1, en2, en3;
  int num_errors = 0;
  int total_checks = 0;

  always #25 aclk = ~aclk;

  gpo_seq_top dut_u
  (
    .aclk(aclk), .aresetn(aresetn),
    .otp_out0_delay(otp_d0), .otp_out1_delay(otp_d1),
    .otp_out2_delay(otp_d2), .otp_ctrl_first(otp_c1),
    .otp_ctrl_second(otp_c2), .otp_config(otp_cfg),
    .enable_pin_one(en1), .enable_pin_two(en2), .enable_pin_three(en3),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .general_out_a_o(o[0]), .general_out_a_oe_n(oe_n[0]),
    .general_out_b_o(o[1]), .general_out_b_oe_n(oe_n[1]),
    .power_good_sel(pg_sel),
    .general_out_c_o(o[2]), .general_out_c_oe_n(oe_n[2]),
    .general_out_c_sel(c_sel)
  );

  host_pins_model host_u
  (
    .aclk(aclk), .en_req(en_req), .pad_o(o), .pad_oe_n(oe_n),
    .enable_pin_one(en1), .enable_pin_two(en2), .enable_pin_three(en3),
    .pad_level(pin)
  );

  task automatic stop_test();
    if (num_errors == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // one edge of a bounded wait; a hang ends the run
  task automatic step(inout int n, input int lim);
    @(posedge aclk);
    n++;
    if (n > lim)
    begin
      $display("unexpected handshake exp 1 got 0");
      num_errors++;
      stop_test();
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d,
                    input logic [3:0] st);
    int n;
    logic aw_ok;
    logic w_ok;
    n = 0;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= {22'h0, idx, 2'b00};
    wdata <= {24'h0, d};
    wstrb <= st;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      step(n, 100);
      if (awready && !aw_ok)
      begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready && !w_ok)
      begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    // raised only once both are taken, so back-to-back calls never
    // lower and raise it in one time step
    bready <= 1'b1;
    do step(n, 100); while (!bvalid);
    bready <= 1'b0;
    `CHK("write response", bresp, 2'b00)
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp,
                    input logic [1:0] er, input string nm);
    int n;
    n = 0;
    araddr <= {22'h0, idx, 2'b00};
    arvalid <= 1'b1;
    do step(n, 100); while (!arready);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do step(n, 100); while (!rvalid);
    rready <= 1'b0;
    `CHK(nm, rdata, {24'h0, exp})
    `CHK(nm, rresp, er)
  endtask

  // counts edges until output bit b shows v; must land in (lo, hi]
  task automatic wait_out(input int b, input logic v, input int lo,
                          input int hi, input string nm);
    int n;
    n = 0;
    while (o[b] !== v && n <= hi)
    begin
      @(posedge aclk);
      n++;
    end
    `CHK(nm, (n > lo) && (n <= hi), 1'b1)
  endtask

  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    rd(`IDX_OUT0_DELAY, otp_d0, 2'b00, "out0 delay");
    rd(`IDX_OUT1_DELAY, otp_d1, 2'b00, "out1 delay");
    rd(`IDX_OUT2_DELAY, otp_d2, 2'b00, "out2 delay");
    rd(`IDX_CTRL_FIRST, otp_c1, 2'b00, "ctrl first");
    rd(`IDX_CTRL_SECOND, otp_c2, 2'b00, "ctrl second");
    rd(`IDX_CONFIG, otp_cfg, 2'b00, "config");
    rd(8'h12, 8'h00, 2'b10, "unmapped");
    `CHK("reset outputs", o, 3'b001)
    `CHK("b select", pg_sel, 1'b0)
    `CHK("c select", c_sel, 1'b1)
    wr(`IDX_CTRL_FIRST, 8'h55, 4'h0);
    rd(`IDX_CTRL_FIRST, otp_c1, 2'b00, "masked write");
    wr(`IDX_OUT1_DELAY, 8'h00, 4'h1);
    wr(`IDX_OUT2_DELAY, 8'h00, 4'h1);
    // every gating code on all three outputs, drain type alternating
    for (int g = 0; g < 4; g++)
    begin
      en_req <= 3'h7;
      wr(`IDX_CTRL_FIRST, {g[0], g[1:0], 1'b1, g[0], g[1:0], 1'b1}, 4'h1);
      wr(`IDX_CTRL_SECOND, {4'h3, g[0], g[1:0], 1'b1}, 4'h1);
      for (int b = 0; b < 3; b++)
        wait_out(b, 1'b1, -1, 20, "gated high");
      repeat (2) @(posedge aclk);
      `CHK("drain high", oe_n, {3{g[0]}})
      `CHK("pin high", pin, 3'b111)
      if (g != 0)
      begin
        en_req <= ~(3'b001 << (g - 1));
        for (int b = 0; b < 3; b++)
          wait_out(b, 1'b0, -1, 20, "gated low");
        repeat (2) @(posedge aclk);
        `CHK("drain low", oe_n, 3'b000)
        `CHK("pin low", pin, 3'b000)
      end
    end
    en_req <= 3'h7;
    wr(`IDX_CTRL_FIRST, 8'h00, 4'h1);
    wr(`IDX_CTRL_SECOND, 8'h20, 4'h1);
    repeat (2) @(posedge aclk);
    `CHK("power good mode", pg_sel, 1'b1)
    wr(`IDX_CTRL_SECOND, 8'h30, 4'h1);
    // rise scale doubles code 1 to two ticks
    wr(`IDX_CONFIG, 8'h80, 4'h1);
    rd(`IDX_CONFIG, 8'h80, 2'b00, "config write");
    wr(`IDX_OUT0_DELAY, 8'h01, 4'h1);
    wr(`IDX_CTRL_FIRST, 8'h01, 4'h1);
    wait_out(0, 1'b1, t_step - 10, 2 * t_step + 20, "a rise");
    // fall scale is its own bit; rise scale clear must not matter
    wr(`IDX_CONFIG, 8'h40, 4'h1);
    wr(`IDX_OUT0_DELAY, 8'h10, 4'h1);
    wr(`IDX_CTRL_FIRST, 8'h00, 4'h1);
    wait_out(0, 1'b0, t_step - 10, 2 * t_step + 20, "a fall");
    wr(`IDX_CONFIG, 8'h00, 4'h1);
    wr(`IDX_OUT2_DELAY, 8'h02, 4'h1);
    wr(`IDX_CTRL_SECOND, 8'h31, 4'h1);
    wait_out(2, 1'b1, t_step - 10, 2 * t_step + 20, "c rise");
    // code 2 needs at least one full tick, so 200 cycles is always early
    wr(`IDX_OUT1_DELAY, 8'h02, 4'h1);
    wr(`IDX_CTRL_FIRST, 8'h10, 4'h1);
    repeat (200) @(posedge aclk);
    wr(`IDX_CTRL_FIRST, 8'h00, 4'h1);
    for (int i = 0; i < 2 * t_step + 100; i++)
    begin
      @(posedge aclk);
      hi_seen = hi_seen | o[1];
    end
    `CHK("b cancelled", hi_seen, 1'b0)
    stop_test();
  end
endmodule
